//--- supres_regs.svh
/*
  Constants of the supervisor: timing figures, bus identity and array size.
  Assumes inclusion by bare name from the design files that need them.
*/
`ifndef SUPRES_REGS_SVH
`define SUPRES_REGS_SVH

`define SUPRES_CLK_NS 10
`define SUPRES_RST_HOLD_MS 200
`define SUPRES_GLITCH_NS 30
`define SUPRES_DEV_TYPE 4'hA
`define SUPRES_ADDR_W 11
`define SUPRES_PAGE_W 4
`define SUPRES_DATA_W 8

`endif

//--- supres_pkg.sv
/*
  Types of the supervisor: open-drain pin bundle, state enums and the
  packed state records of both clock domains.
  Assumes supres_regs.svh is on the include path.
*/
`include "supres_regs.svh"

package supres_pkg;

  typedef struct packed {
    logic out;
    logic oe_n;
  } supres_od_t;

  typedef enum logic [2:0] {
    SUP_PWR = 3'h1,
    SUP_RUN = 3'h2,
    SUP_MAN = 3'h4
  } supres_sup_st_t;

  typedef enum logic [4:0] {
    BUS_IDLE = 5'h01,
    BUS_RX = 5'h02,
    BUS_RXACK = 5'h04,
    BUS_TX = 5'h08,
    BUS_TXACK = 5'h10
  } supres_bus_st_t;

  typedef enum logic [2:0] {
    ROLE_DEV = 3'h1,
    ROLE_WADR = 3'h2,
    ROLE_DATA = 3'h4
  } supres_role_t;

  typedef struct packed {
    logic vb_s1;
    logic vb_s2;
    logic pin_s1;
    logic pin_s2;
    logic pin_prev;
    logic [7:0] gl_cnt;
    logic [31:0] timer;
    supres_sup_st_t st;
    logic drive_n;
    logic rst_active;
  } supres_sup_t;

  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic lk_s1;
    logic lk_s2;
    logic wp_s1;
    logic wp_s2;
    logic scl_s1;
    logic scl_s2;
    logic scl_prev;
    logic sda_s1;
    logic sda_s2;
    logic sda_prev;
    supres_bus_st_t st;
    supres_role_t role;
    logic [`SUPRES_DATA_W-1:0] shreg;
    logic [3:0] bitcnt;
    logic rnw;
    logic [`SUPRES_ADDR_W-1:0] ptr;
    logic sda_oe_n;
    logic we;
    logic [`SUPRES_ADDR_W-1:0] waddr;
    logic [`SUPRES_DATA_W-1:0] wdata;
  } supres_link_t;

endpackage : supres_pkg

//--- supres_mem.sv
/*
  Single-port-write, registered-read memory array of the supervisor.
  Assumes write and read requests arrive on the same clock.
*/
module supres_mem #(
  parameter int unsigned ADDR_W = 11,
  parameter int unsigned DATA_W = 8
) (
  input wire logic i_clk,
  input wire logic i_we,
  input wire logic [ADDR_W-1:0] i_waddr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic [ADDR_W-1:0] i_raddr,
  output logic [DATA_W-1:0] o_rdata
);

  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end

endmodule : supres_mem

//--- supres_top.sv
/*
  Supply supervisor with open-drain reset pin, manual reset stretch, write
  lockout and a two-wire serial slave in front of the boot memory.
  Assumes an asynchronous below-threshold flag from an analog comparator,
  pads that resolve the open-drain wires, and a free-running link clock.
*/
`include "supres_regs.svh"

module supres_top #(
  parameter int unsigned RST_HOLD_CYC = `SUPRES_RST_HOLD_MS * 1000000 / `SUPRES_CLK_NS
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_link_clk,
  input wire logic i_vcc_below,
  input wire logic i_rst_pin_in,
  output supres_pkg::supres_od_t o_rst_pin,
  input wire logic i_wp,
  input wire logic i_scl,
  input wire logic i_sda_in,
  output supres_pkg::supres_od_t o_sda
);
  import supres_pkg::*;

  localparam logic [7:0] GLITCH_CYC =
    8'((`SUPRES_GLITCH_NS + `SUPRES_CLK_NS - 1) / `SUPRES_CLK_NS);
  localparam logic [31:0] HOLD_LAST = 32'(RST_HOLD_CYC - 1);

  localparam supres_sup_t SUP_RST = '{
    vb_s1: 1'b0,
    vb_s2: 1'b0,
    pin_s1: 1'b1,
    pin_s2: 1'b1,
    pin_prev: 1'b1,
    gl_cnt: 8'h00,
    timer: 32'h0000_0000,
    st: SUP_PWR,
    drive_n: 1'b0,
    rst_active: 1'b1
  };

  localparam supres_link_t LINK_RST = '{
    rst_s1: 1'b1,
    rst_s2: 1'b1,
    lk_s1: 1'b1,
    lk_s2: 1'b1,
    wp_s1: 1'b1,
    wp_s2: 1'b1,
    scl_s1: 1'b1,
    scl_s2: 1'b1,
    scl_prev: 1'b1,
    sda_s1: 1'b1,
    sda_s2: 1'b1,
    sda_prev: 1'b1,
    st: BUS_IDLE,
    role: ROLE_DEV,
    shreg: '0,
    bitcnt: 4'h0,
    rnw: 1'b0,
    ptr: '0,
    sda_oe_n: 1'b1,
    we: 1'b0,
    waddr: '0,
    wdata: '0
  };

  // Page-wrapping increment for writes, full increment for reads
  function automatic logic [`SUPRES_ADDR_W-1:0] next_addr(
    input logic [`SUPRES_ADDR_W-1:0] a,
    input logic page
  );
    logic [`SUPRES_ADDR_W-1:0] r;
    r = a + 1'b1;
    if (page) begin
      r[`SUPRES_ADDR_W-1:`SUPRES_PAGE_W] = a[`SUPRES_ADDR_W-1:`SUPRES_PAGE_W];
    end
    return r;
  endfunction : next_addr

  supres_sup_t sup;
  supres_sup_t next_sup;
  supres_link_t lnk;
  supres_link_t next_lnk;
  logic [`SUPRES_DATA_W-1:0] rdata;
  logic trip;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic locked;

  // Supervisor domain on the block's own clock
  always_comb begin
    next_sup = sup;
    next_sup.vb_s1 = i_vcc_below;
    next_sup.vb_s2 = sup.vb_s1;
    next_sup.pin_s1 = i_rst_pin_in;
    next_sup.pin_s2 = sup.pin_s1;
    next_sup.pin_prev = sup.pin_s2;
    trip = sup.vb_s2 && (sup.gl_cnt >= GLITCH_CYC);
    if (!sup.vb_s2) begin
      next_sup.gl_cnt = 8'h00;
    end else if (sup.gl_cnt < GLITCH_CYC) begin
      next_sup.gl_cnt = sup.gl_cnt + 8'h01;
    end
    case (sup.st)
      SUP_PWR, SUP_MAN: begin
        if (sup.vb_s2) begin
          next_sup.timer = 32'h0000_0000;
          next_sup.st = SUP_PWR;
        end else if (sup.timer >= HOLD_LAST) begin
          next_sup.timer = 32'h0000_0000;
          next_sup.st = SUP_RUN;
        end else begin
          next_sup.timer = sup.timer + 32'h0000_0001;
        end
      end
      SUP_RUN: begin
        if (trip) begin
          next_sup.timer = 32'h0000_0000;
          next_sup.st = SUP_PWR;
        end else if (sup.pin_prev && !sup.pin_s2) begin
          next_sup.timer = 32'h0000_0000;
          next_sup.st = SUP_MAN;
        end
      end
      default: begin
        next_sup.st = SUP_PWR;
      end
    endcase
    // Released drive leaves an external hold visible on the wire
    next_sup.drive_n = (next_sup.st == SUP_RUN);
    next_sup.rst_active = (next_sup.st != SUP_RUN) || !sup.pin_s2;
    if (i_sys_rst) begin
      next_sup = SUP_RST;
    end
  end

  always_ff @(posedge i_clk) begin
    sup <= next_sup;
  end

  assign o_rst_pin = '{out: 1'b0, oe_n: sup.drive_n};

  // Link domain on the link clock
  always_comb begin
    scl_rise = lnk.scl_s2 && !lnk.scl_prev;
    scl_fall = !lnk.scl_s2 && lnk.scl_prev;
    start_seen = lnk.scl_s2 && lnk.scl_prev && lnk.sda_prev && !lnk.sda_s2;
    stop_seen = lnk.scl_s2 && lnk.scl_prev && !lnk.sda_prev && lnk.sda_s2;
    locked = lnk.lk_s2 || lnk.wp_s2;
    next_lnk = lnk;
    next_lnk.rst_s1 = i_sys_rst;
    next_lnk.rst_s2 = lnk.rst_s1;
    next_lnk.lk_s1 = sup.rst_active;
    next_lnk.lk_s2 = lnk.lk_s1;
    next_lnk.wp_s1 = i_wp;
    next_lnk.wp_s2 = lnk.wp_s1;
    next_lnk.scl_s1 = i_scl;
    next_lnk.scl_s2 = lnk.scl_s1;
    next_lnk.scl_prev = lnk.scl_s2;
    next_lnk.sda_s1 = i_sda_in;
    next_lnk.sda_s2 = lnk.sda_s1;
    next_lnk.sda_prev = lnk.sda_s2;
    next_lnk.we = 1'b0;
    if (start_seen) begin
      next_lnk.st = BUS_RX;
      next_lnk.role = ROLE_DEV;
      next_lnk.bitcnt = 4'h0;
      next_lnk.sda_oe_n = 1'b1;
    end else if (stop_seen) begin
      next_lnk.st = BUS_IDLE;
      next_lnk.sda_oe_n = 1'b1;
    end else begin
      case (lnk.st)
        BUS_IDLE: begin
          next_lnk.sda_oe_n = 1'b1;
        end
        BUS_RX: begin
          if (scl_rise && lnk.bitcnt < 4'h8) begin
            next_lnk.shreg = {lnk.shreg[`SUPRES_DATA_W-2:0], lnk.sda_s2};
            next_lnk.bitcnt = lnk.bitcnt + 4'h1;
          end else if (scl_fall && lnk.bitcnt == 4'h8) begin
            next_lnk.bitcnt = 4'h0;
            next_lnk.st = BUS_RXACK;
            next_lnk.sda_oe_n = 1'b0;
            case (lnk.role)
              ROLE_DEV: begin
                if (lnk.shreg[7:4] == `SUPRES_DEV_TYPE) begin
                  next_lnk.ptr[`SUPRES_ADDR_W-1:8] = lnk.shreg[3:1];
                  next_lnk.rnw = lnk.shreg[0];
                end else begin
                  next_lnk.st = BUS_IDLE;
                  next_lnk.sda_oe_n = 1'b1;
                end
              end
              ROLE_WADR: begin
                next_lnk.ptr[7:0] = lnk.shreg;
              end
              default: begin
                if (!locked) begin
                  next_lnk.we = 1'b1;
                  next_lnk.waddr = lnk.ptr;
                  next_lnk.wdata = lnk.shreg;
                end
                next_lnk.ptr = next_addr(lnk.ptr, 1'b1);
              end
            endcase
          end
        end
        BUS_RXACK: begin
          if (scl_fall) begin
            next_lnk.bitcnt = 4'h0;
            if (lnk.role == ROLE_DEV && lnk.rnw) begin
              next_lnk.st = BUS_TX;
              next_lnk.sda_oe_n = rdata[7];
              next_lnk.shreg = {rdata[6:0], 1'b1};
              next_lnk.bitcnt = 4'h1;
              next_lnk.ptr = next_addr(lnk.ptr, 1'b0);
            end else begin
              next_lnk.st = BUS_RX;
              next_lnk.sda_oe_n = 1'b1;
              next_lnk.role = (lnk.role == ROLE_DEV) ? ROLE_WADR : ROLE_DATA;
            end
          end
        end
        BUS_TX: begin
          if (scl_fall) begin
            if (lnk.bitcnt == 4'h8) begin
              next_lnk.sda_oe_n = 1'b1;
              next_lnk.st = BUS_TXACK;
            end else if (lnk.bitcnt == 4'h0) begin
              next_lnk.sda_oe_n = rdata[7];
              next_lnk.shreg = {rdata[6:0], 1'b1};
              next_lnk.bitcnt = 4'h1;
              next_lnk.ptr = next_addr(lnk.ptr, 1'b0);
            end else begin
              next_lnk.sda_oe_n = lnk.shreg[7];
              next_lnk.shreg = {lnk.shreg[6:0], 1'b1};
              next_lnk.bitcnt = lnk.bitcnt + 4'h1;
            end
          end
        end
        BUS_TXACK: begin
          if (scl_rise) begin
            if (!lnk.sda_s2) begin
              next_lnk.st = BUS_TX;
              next_lnk.bitcnt = 4'h0;
            end else begin
              next_lnk.st = BUS_IDLE;
            end
          end
        end
        default: begin
          next_lnk.st = BUS_IDLE;
        end
      endcase
    end
    if (lnk.rst_s2) begin
      next_lnk = LINK_RST;
      next_lnk.rst_s1 = i_sys_rst;
      next_lnk.rst_s2 = lnk.rst_s1;
    end
  end

  always_ff @(posedge i_link_clk) begin
    lnk <= next_lnk;
  end

  assign o_sda = '{out: 1'b0, oe_n: lnk.sda_oe_n};

  supres_mem #(
    .ADDR_W(`SUPRES_ADDR_W),
    .DATA_W(`SUPRES_DATA_W)
  ) u_mem (
    .i_clk(i_link_clk),
    .i_we(lnk.we),
    .i_waddr(lnk.waddr),
    .i_wdata(lnk.wdata),
    .i_raddr(lnk.ptr),
    .o_rdata(rdata)
  );

endmodule : supres_top

//--- supres_monitor.sv
/* Port checker of the supervisor.
   Assumes the bind below and wire levels already resolved at the inputs. */
module supres_monitor #(
  parameter int unsigned RST_HOLD_CYC = 50
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_link_clk,
  input wire logic i_vcc_below,
  input wire logic i_rst_pin_in,
  input wire supres_pkg::supres_od_t o_rst_pin,
  input wire logic i_wp,
  input wire logic i_scl,
  input wire logic i_sda_in,
  input wire supres_pkg::supres_od_t o_sda
);
  timeunit 1ns;
  timeprecision 1ps;
  import supres_pkg::*;
  logic [31:0] up_cnt;
  logic [31:0] low_cnt;
  // Supply-good run length and reset-low run length
  always_ff @(posedge i_clk) begin
    up_cnt <= (i_sys_rst || i_vcc_below) ? 32'h0 : up_cnt + 32'h1;
    low_cnt <= (i_sys_rst || i_vcc_below || o_rst_pin.oe_n) ? 32'h0 : low_cnt + 32'h1;
  end
  rst_drive_a: assert property (@(posedge i_clk) i_sys_rst |=> !o_rst_pin.oe_n)
    else $error("reset wire free in reset");
  open_drain_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_rst_pin.out == 1'h0 && o_sda.out == 1'h0) else $error("pin driven high");
  brown_out_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_vcc_below [*8] |=> !o_rst_pin.oe_n) else $error("brownout missed");
  hold_min_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $rose(o_rst_pin.oe_n) |-> up_cnt >= RST_HOLD_CYC) else $error("hold short");
  hold_max_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    low_cnt <= RST_HOLD_CYC + 8) else $error("hold long");
  man_start_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $fell(i_rst_pin_in) && o_rst_pin.oe_n && !i_vcc_below |-> ##[1:5] !o_rst_pin.oe_n)
    else $error("manual edge missed");
  sda_stable_a: assert property (@(posedge i_link_clk) disable iff (i_sys_rst)
    i_scl && $past(i_scl) |-> $stable(o_sda.oe_n)) else $error("data moved, clock high");
  stop_quiet_a: assert property (@(posedge i_link_clk) disable iff (i_sys_rst)
    i_scl && $past(i_scl) && $rose(i_sda_in) |=> o_sda.oe_n [*8])
    else $error("driven after stop");
endmodule : supres_monitor

bind supres_top supres_monitor #(.RST_HOLD_CYC(RST_HOLD_CYC)) u_mon (.i_clk(i_clk),
  .i_sys_rst(i_sys_rst), .i_link_clk(i_link_clk), .i_vcc_below(i_vcc_below),
  .i_rst_pin_in(i_rst_pin_in), .o_rst_pin(o_rst_pin), .i_wp(i_wp), .i_scl(i_scl),
  .i_sda_in(i_sda_in), .o_sda(o_sda));

//--- supres_host.sv
/* Two-wire bus master in the host's place.
   Assumes the bench resolves the pulled-up data wire. */
module supres_host (
  input wire logic i_link_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  import supres_pkg::*;
  initial begin
    o_scl = 1'h1;
    o_sda_oe_n = 1'h1;
  end
  task automatic gap();
    repeat (4) @(posedge i_link_clk);
  endtask : gap
  // Bus brought idle first
  task automatic start();
    gap();
    o_sda_oe_n <= 1'h1;
    gap();
    o_scl <= 1'h1;
    gap();
    o_sda_oe_n <= 1'h0;
    gap();
    o_scl <= 1'h0;
  endtask : start
  task automatic stop();
    gap();
    o_sda_oe_n <= 1'h0;
    gap();
    o_scl <= 1'h1;
    gap();
    o_sda_oe_n <= 1'h1;
    gap();
  endtask : stop
  // Eight bits and the acknowledge slot, most significant first
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      gap();
      o_sda_oe_n <= tx[i];
      gap();
      o_scl <= 1'h1;
      gap();
      rx[i] = i_sda;
      gap();
      o_scl <= 1'h0;
    end
  endtask : xfer
endmodule : supres_host

//--- tb.sv
/* Bench of the supervisor: power-up, glitch, brownout, manual reset,
   bus traffic and write lockout. Assumes supres_host on the serial pins. */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import supres_pkg::*;
  localparam int unsigned HOLD = 50;
  logic clk = 1'h0;
  logic lclk = 1'h0;
  logic sys_rst = 1'h1;
  logic vcc_below = 1'h0;
  logic ext_n = 1'h1;
  logic wp = 1'h0;
  logic scl;
  logic m_oe_n;
  supres_od_t rst_od;
  supres_od_t sda_od;
  wire logic rst_w = ext_n & rst_od.oe_n;
  wire logic sda_w = m_oe_n & sda_od.oe_n;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [8:0] r;
  always #5 clk = ~clk;
  always #16 lclk = ~lclk;
  supres_top #(.RST_HOLD_CYC(HOLD)) dut (.i_clk(clk), .i_sys_rst(sys_rst),
    .i_link_clk(lclk), .i_vcc_below(vcc_below), .i_rst_pin_in(rst_w),
    .o_rst_pin(rst_od), .i_wp(wp), .i_scl(scl), .i_sda_in(sda_w), .o_sda(sda_od));
  supres_host host (.i_link_clk(lclk), .i_sda(sda_w), .o_scl(scl), .o_sda_oe_n(m_oe_n));
  task automatic stop_test();
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      stop_test();
    end
  end
  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask : w
  task automatic bwr(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1);
    host.start();
    host.xfer({8'hA0, 1'h1}, r);
    host.xfer({a, 1'h1}, r);
    host.xfer({d0, 1'h1}, r);
    host.xfer({d1, 1'h1}, r);
    chk("ack", 9'h0, {8'h0, r[0]});
    host.stop();
  endtask : bwr
  task automatic brd(input logic [7:0] a, input logic [7:0] e0, input logic [7:0] e1);
    host.start();
    host.xfer({8'hA0, 1'h1}, r);
    host.xfer({a, 1'h1}, r);
    host.start();
    host.xfer({8'hA1, 1'h1}, r);
    host.xfer({8'hFF, 1'h0}, r);
    chk("rd0", {1'h0, e0}, {1'h0, r[8:1]});
    host.xfer(9'h1FF, r);
    chk("rd1", {1'h0, e1}, {1'h0, r[8:1]});
    host.stop();
  endtask : brd
  // Current-address read, master refuses the byte
  task automatic crd(input logic [7:0] e0);
    host.start();
    host.xfer({8'hA1, 1'h1}, r);
    host.xfer(9'h1FF, r);
    chk("rd_cur", {1'h0, e0}, {1'h0, r[8:1]});
    host.stop();
  endtask : crd
  task automatic t_power();
    w(12);
    @(posedge clk) sys_rst <= 1'h0;
    w(HOLD);
    chk("pwr_hold", 0, rst_w);
    w(10);
    chk("pwr_free", 1, rst_od.oe_n);
    $display("power-up end");
  endtask : t_power
  task automatic t_supply();
    @(posedge clk) vcc_below <= 1'h1;
    @(posedge clk);
    @(posedge clk) vcc_below <= 1'h0;
    w(20);
    chk("glitch", 1, rst_od.oe_n);
    @(posedge clk) vcc_below <= 1'h1;
    w(10);
    chk("brown", 0, rst_w);
    @(posedge clk) vcc_below <= 1'h0;
    w(HOLD + 10);
    chk("brown_end", 1, rst_w);
    $display("brownout end");
  endtask : t_supply
  task automatic t_manual();
    @(posedge clk) ext_n <= 1'h0;
    w(5);
    @(posedge clk) ext_n <= 1'h1;
    w(5);
    chk("man_start", 0, rst_od.oe_n);
    w(HOLD - 10);
    chk("man_stretch", 0, rst_w);
    w(20);
    chk("man_end", 1, rst_w);
    @(posedge clk) ext_n <= 1'h0;
    w(HOLD + 20);
    chk("man_long", 9'h002, {rst_od.oe_n, rst_w});
    @(posedge clk) ext_n <= 1'h1;
    w(20);
    chk("man_norearm", 1, rst_w);
    $display("manual end");
  endtask : t_manual
  task automatic t_bus();
    bwr(8'h20, 8'hC3, 8'h5A);
    brd(8'h20, 8'hC3, 8'h5A);
    bwr(8'h40, 8'h88, 8'h99);
    bwr(8'h3F, 8'h66, 8'h77);
    brd(8'h3F, 8'h66, 8'h88);
    crd(8'h99);
    host.start();
    host.xfer({8'h90, 1'h1}, r);
    chk("foreign_nack", 1, r[0]);
    host.stop();
    $display("bus end");
  endtask : t_bus
  task automatic t_lockout();
    @(posedge clk) wp <= 1'h1;
    bwr(8'h20, 8'h11, 8'h22);
    @(posedge clk) wp <= 1'h0;
    @(posedge clk) vcc_below <= 1'h1;
    w(10);
    bwr(8'h20, 8'h33, 8'h44);
    @(posedge clk) vcc_below <= 1'h0;
    w(HOLD + 10);
    brd(8'h20, 8'hC3, 8'h5A);
    $display("lockout end");
  endtask : t_lockout
  initial begin
    t_power();
    t_supply();
    t_manual();
    t_bus();
    t_lockout();
    stop_test();
  end
endmodule : tb
